// File: rtl/mfd_decoder.sv
// Purpose: Registered decoder for memory-format (load/store) instructions
// Assumes: INSTR_VALID and INSTR come from the fetch stage each cycle
// Notes: One cycle of latency; nothing here executes an access
`timescale 1ns/1ns
module mfd_decoder
  import mfd_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  output mfd_result_type RESULT
);

  logic [5:0] opcode;
  logic imm_sel;
  logic is_mem;
  mfd_class_type op_class;
  mfd_attr_type attr;
  logic alt_space;
  logic known;
  mfd_result_type next_result;

  assign opcode = INSTR[MFD_OP_HI:MFD_OP_LO];
  assign imm_sel = INSTR[MFD_IMM_SEL];
  assign is_mem = INSTR[MFD_FMT_HI:MFD_FMT_LO] == MFD_FMT_MEM;

  mfd_opcode_table u_table (
    .opcode(opcode),
    .imm_sel(imm_sel),
    .op_class(op_class),
    .attr(attr),
    .alt_space(alt_space),
    .known(known)
  );

  // Fields are passed through even when illegal, which helps trap reporting
  always_comb begin
    next_result = MFD_RESULT_RESET;
    if (INSTR_VALID && is_mem) begin
      next_result.valid = known;
      next_result.illegal = !known;
      next_result.op_class = op_class;
      next_result.opcode = opcode;
      next_result.attr = known ? attr : '0;
      next_result.dest_register = INSTR[MFD_RD_HI:MFD_RD_LO];
      next_result.first_source_register =
        INSTR[MFD_RS1_HI:MFD_RS1_LO];
      next_result.use_immediate = imm_sel && !alt_space;
      if (imm_sel && !alt_space) begin
        next_result.signed_immediate_field =
          {{19{INSTR[MFD_IMM_HI]}}, INSTR[MFD_IMM_HI:0]};
      end else begin
        next_result.second_source_register =
          INSTR[MFD_RS2_HI:0];
      end
      if (alt_space) begin
        next_result.space_id = INSTR[MFD_ASI_HI:MFD_ASI_LO];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RESULT <= MFD_RESULT_RESET;
    end else begin
      RESULT <= next_result;
    end
  end

endmodule

// File: rtl/mfd_opcode_table.sv
// Purpose: Opcode recognition table for memory-format instructions
// Assumes: Opcode and immediate-select bit are already extracted
// Notes: Purely combinational; the top module registers its result
`timescale 1ns/1ns
module mfd_opcode_table
  import mfd_pkg::*;
(
  input wire logic [5:0] opcode,
  input wire logic imm_sel,
  output mfd_class_type op_class,
  output mfd_attr_type attr,
  output logic alt_space,
  output logic known
);

  function automatic mfd_attr_type mk(input logic ld, input logic st,
                                      input logic at, input logic sx,
                                      input logic [1:0] sz);
    mk = '{is_load: ld, is_store: st, is_atomic: at, sign_ext: sx,
           size: sz};
  endfunction

  always_comb begin
    op_class = MFD_CLS_NONE;
    attr = '0;
    alt_space = 1'b0;
    known = 1'b1;
    unique case (opcode)
      OP_LOAD_SIGNED_BYTE: begin
        op_class = MFD_CLS_INT;
        attr = mk(1'b1, 1'b0, 1'b0, 1'b1, MFD_SZ_BYTE);
      end
      OP_LOAD_SIGNED_HALF: begin
        op_class = MFD_CLS_INT;
        attr = mk(1'b1, 1'b0, 1'b0, 1'b1, MFD_SZ_HALF);
      end
      OP_ATOMIC_LOAD_SET_BYTE: begin
        op_class = MFD_CLS_INT;
        attr = mk(1'b1, 1'b1, 1'b1, 1'b0, MFD_SZ_BYTE);
      end
      OP_EXCHANGE: begin
        op_class = MFD_CLS_INT;
        attr = mk(1'b1, 1'b1, 1'b1, 1'b0, MFD_SZ_WORD);
      end
      OP_ALT_SPACE_WORD_LOAD: begin
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_WORD);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_UBYTE_LOAD: begin
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_BYTE);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_UHALF_LOAD: begin
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_HALF);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_DOUBLE_LOAD: begin
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_DOUBLE);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_WORD_STORE: begin
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_WORD);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_BYTE_STORE: begin
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_BYTE);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_HALF_STORE: begin
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_HALF);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_DOUBLE_STORE: begin
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_DOUBLE);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_SBYTE_LOAD: begin
        attr = mk(1'b1, 1'b0, 1'b0, 1'b1, MFD_SZ_BYTE);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_SHALF_LOAD: begin
        attr = mk(1'b1, 1'b0, 1'b0, 1'b1, MFD_SZ_HALF);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_ATOMIC_SET_BYTE: begin
        attr = mk(1'b1, 1'b1, 1'b1, 1'b0, MFD_SZ_BYTE);
        alt_space = 1'b1;
      end
      OP_ALT_SPACE_EXCHANGE: begin
        attr = mk(1'b1, 1'b1, 1'b1, 1'b0, MFD_SZ_WORD);
        alt_space = 1'b1;
      end
      OP_FP_SINGLE_LOAD, OP_FP_STATUS_LOAD: begin
        op_class = MFD_CLS_FP;
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_WORD);
      end
      OP_FP_DOUBLE_LOAD: begin
        op_class = MFD_CLS_FP;
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_DOUBLE);
      end
      OP_FP_SINGLE_STORE, OP_FP_STATUS_STORE: begin
        op_class = MFD_CLS_FP;
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_WORD);
      end
      OP_FP_DOUBLE_STORE, OP_FP_QUEUE_STORE: begin
        op_class = MFD_CLS_FP;
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_DOUBLE);
      end
      OP_COPRO_SINGLE_LOAD, OP_COPRO_STATUS_LOAD: begin
        op_class = MFD_CLS_COPRO;
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_WORD);
      end
      OP_COPRO_DOUBLE_LOAD: begin
        op_class = MFD_CLS_COPRO;
        attr = mk(1'b1, 1'b0, 1'b0, 1'b0, MFD_SZ_DOUBLE);
      end
      OP_COPRO_SINGLE_STORE, OP_COPRO_STATUS_STORE: begin
        op_class = MFD_CLS_COPRO;
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_WORD);
      end
      OP_COPRO_DOUBLE_STORE, OP_COPRO_QUEUE_STORE: begin
        op_class = MFD_CLS_COPRO;
        attr = mk(1'b0, 1'b1, 1'b0, 1'b0, MFD_SZ_DOUBLE);
      end
      default: begin
        known = 1'b0;
      end
    endcase
    // Alternate-space forms with the immediate bit set are not legal
    if (alt_space) begin
      op_class = imm_sel ? MFD_CLS_NONE : MFD_CLS_ALT;
      known = !imm_sel;
    end
  end

endmodule

// File: rtl/mfd_pkg.sv
// Purpose: Shared constants and types for the memory-format decoder
// Assumes: 32-bit instruction words, fields at fixed positions
// Notes: Operation codes are the six-bit field of a memory-format word
package mfd_pkg;

  localparam int MFD_FMT_HI = 31;
  localparam int MFD_FMT_LO = 30;
  localparam logic [1:0] MFD_FMT_MEM = 2'h3;
  localparam int MFD_RD_HI = 29;
  localparam int MFD_RD_LO = 25;
  localparam int MFD_OP_HI = 24;
  localparam int MFD_OP_LO = 19;
  localparam int MFD_RS1_HI = 18;
  localparam int MFD_RS1_LO = 14;
  localparam int MFD_IMM_SEL = 13;
  localparam int MFD_ASI_HI = 12;
  localparam int MFD_ASI_LO = 5;
  localparam int MFD_IMM_HI = 12;
  localparam int MFD_RS2_HI = 4;

  localparam logic [5:0] OP_LOAD_SIGNED_BYTE = 6'h09;
  localparam logic [5:0] OP_LOAD_SIGNED_HALF = 6'h0a;
  localparam logic [5:0] OP_ATOMIC_LOAD_SET_BYTE = 6'h0d;
  localparam logic [5:0] OP_EXCHANGE = 6'h0f;
  localparam logic [5:0] OP_ALT_SPACE_WORD_LOAD = 6'h10;
  localparam logic [5:0] OP_ALT_SPACE_UBYTE_LOAD = 6'h11;
  localparam logic [5:0] OP_ALT_SPACE_UHALF_LOAD = 6'h12;
  localparam logic [5:0] OP_ALT_SPACE_DOUBLE_LOAD = 6'h13;
  localparam logic [5:0] OP_ALT_SPACE_WORD_STORE = 6'h14;
  localparam logic [5:0] OP_ALT_SPACE_BYTE_STORE = 6'h15;
  localparam logic [5:0] OP_ALT_SPACE_HALF_STORE = 6'h16;
  localparam logic [5:0] OP_ALT_SPACE_DOUBLE_STORE = 6'h17;
  localparam logic [5:0] OP_ALT_SPACE_SBYTE_LOAD = 6'h19;
  localparam logic [5:0] OP_ALT_SPACE_SHALF_LOAD = 6'h1a;
  localparam logic [5:0] OP_ALT_SPACE_ATOMIC_SET_BYTE = 6'h1d;
  localparam logic [5:0] OP_ALT_SPACE_EXCHANGE = 6'h1f;
  localparam logic [5:0] OP_FP_SINGLE_LOAD = 6'h20;
  localparam logic [5:0] OP_FP_STATUS_LOAD = 6'h21;
  localparam logic [5:0] OP_FP_DOUBLE_LOAD = 6'h23;
  localparam logic [5:0] OP_FP_SINGLE_STORE = 6'h24;
  localparam logic [5:0] OP_FP_STATUS_STORE = 6'h25;
  localparam logic [5:0] OP_FP_QUEUE_STORE = 6'h26;
  localparam logic [5:0] OP_FP_DOUBLE_STORE = 6'h27;
  localparam logic [5:0] OP_COPRO_SINGLE_LOAD = 6'h30;
  localparam logic [5:0] OP_COPRO_STATUS_LOAD = 6'h31;
  localparam logic [5:0] OP_COPRO_DOUBLE_LOAD = 6'h33;
  localparam logic [5:0] OP_COPRO_SINGLE_STORE = 6'h34;
  localparam logic [5:0] OP_COPRO_STATUS_STORE = 6'h35;
  localparam logic [5:0] OP_COPRO_QUEUE_STORE = 6'h36;
  localparam logic [5:0] OP_COPRO_DOUBLE_STORE = 6'h37;

  // One-hot operation class presented to the pipeline
  typedef enum logic [4:0] {
    MFD_CLS_NONE = 5'h01,
    MFD_CLS_INT = 5'h02,
    MFD_CLS_ALT = 5'h04,
    MFD_CLS_FP = 5'h08,
    MFD_CLS_COPRO = 5'h10
  } mfd_class_type;

  typedef struct packed {
    logic is_load;
    logic is_store;
    logic is_atomic;
    logic sign_ext;
    logic [1:0] size;
  } mfd_attr_type;

  localparam logic [1:0] MFD_SZ_BYTE = 2'h0;
  localparam logic [1:0] MFD_SZ_HALF = 2'h1;
  localparam logic [1:0] MFD_SZ_WORD = 2'h2;
  localparam logic [1:0] MFD_SZ_DOUBLE = 2'h3;

  typedef struct packed {
    logic valid;
    logic illegal;
    mfd_class_type op_class;
    logic [5:0] opcode;
    mfd_attr_type attr;
    logic [4:0] dest_register;
    logic [4:0] first_source_register;
    logic [4:0] second_source_register;
    logic use_immediate;
    logic [31:0] signed_immediate_field;
    logic [7:0] space_id;
  } mfd_result_type;

  localparam mfd_result_type MFD_RESULT_RESET = '0;

endpackage

// File: tb/mfd_decoder_assertions.sv
// Purpose: Concurrent checks on the memory-format decoder ports
// Assumes: One clock, synchronous active-high reset, one cycle latency
// Notes: prev holds the word that the decoder sampled one edge earlier
`timescale 1ns/1ns
module mfd_decoder_checker
  import mfd_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR,
  input mfd_result_type RESULT
);
  logic [31:0] prev;
  logic rst_q;
  logic mem;
  logic alt;
  mfd_result_type r;
  assign r = RESULT;
  assign mem = INSTR_VALID && INSTR[31:30] == 2'h3;
  assign alt = mem && INSTR[24:23] == 2'h1;
  always_ff @(posedge CLK_SYS) begin
    prev <= INSTR;
  end
  // Reset drops on an edge, so that edge's attempts must be skipped too
  always_ff @(posedge CLK_SYS) begin
    rst_q <= RST;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST || rst_q);
  nonmem_zero_a: assert property (!mem |=> r == '0)
    else $error("refused word gave a result");
  field_copy_a: assert property (mem |=>
    r.opcode == prev[24:19] && r.dest_register == prev[29:25] &&
    r.first_source_register == prev[18:14])
    else $error("code or register field wrong");
  imm_sext_a: assert property (mem && !alt && INSTR[13] |=>
    !r.valid || (r.use_immediate && r.second_source_register == 5'h00 &&
    r.signed_immediate_field == {{19{prev[12]}}, prev[12:0]}))
    else $error("immediate operand wrong");
  reg_src_a: assert property (mem && !INSTR[13] |=> !r.valid ||
    (!r.use_immediate && r.second_source_register == prev[4:0] &&
    r.signed_immediate_field == 32'h0))
    else $error("register operand wrong");
  alt_imm_a: assert property (alt && INSTR[13] |=>
    r.illegal && !r.valid)
    else $error("alternate space with immediate accepted");
  alt_id_a: assert property (alt && !INSTR[13] |=> !r.valid ||
    (r.space_id == prev[12:5] && r.op_class == MFD_CLS_ALT))
    else $error("space identifier or class wrong");
  sign_load_a: assert property (mem &&
    INSTR[24:19] inside {6'h09, 6'h0a} |=>
    r.valid && r.op_class == MFD_CLS_INT && r.attr.sign_ext)
    else $error("signed load not decoded");
  atomic_op_a: assert property (mem && !INSTR[13] &&
    INSTR[24:19] inside {6'h0d, 6'h0f, 6'h1d, 6'h1f} |=>
    r.valid && r.attr.is_atomic)
    else $error("atomic operation not flagged");
  fp_class_a: assert property (mem && INSTR[24:22] == 3'h4 &&
    INSTR[21:19] != 3'h2 |=> r.valid && r.op_class == MFD_CLS_FP)
    else $error("floating-point class wrong");
  illegal_code_a: assert property (mem && INSTR[24:19] inside
    {6'h00, 6'h0e, 6'h18, 6'h22, 6'h32, 6'h3f} |=> r.illegal &&
    r.op_class == MFD_CLS_NONE && r.attr == '0)
    else $error("unlisted code not refused");
  cover property (r.valid && r.op_class == MFD_CLS_ALT);
  cover property (r.valid && r.use_immediate);
  cover property (r.illegal);
endmodule

bind mfd_decoder mfd_decoder_checker i_mfd_decoder_checker (
  .CLK_SYS(CLK_SYS),
  .RST(RST),
  .INSTR_VALID(INSTR_VALID),
  .INSTR(INSTR),
  .RESULT(RESULT)
);

// File: tb/mfd_decoder_tb.sv
// Purpose: Self-checking bench for the memory-format decoder
// Assumes: Words reach the decoder through the fetch model
// Notes: A monitor predicts each cycle from the word the decoder sampled
`timescale 1ns/1ns
module mfd_decoder_tb import mfd_pkg::*;;
  typedef struct packed {
    logic [5:0] op;
    logic [5:0] attr;
  } mfd_row_type;
  // Zero attr marks a code that must come back illegal
  mfd_row_type rows [36] = '{
    '{6'h09,6'h24}, '{6'h0a,6'h25}, '{6'h0d,6'h38},
    '{6'h0f,6'h3a}, '{6'h10,6'h22}, '{6'h11,6'h20},
    '{6'h12,6'h21}, '{6'h13,6'h23}, '{6'h14,6'h12},
    '{6'h15,6'h10}, '{6'h16,6'h11}, '{6'h17,6'h13},
    '{6'h19,6'h24}, '{6'h1a,6'h25}, '{6'h1d,6'h38},
    '{6'h1f,6'h3a}, '{6'h20,6'h22}, '{6'h21,6'h22},
    '{6'h23,6'h23}, '{6'h24,6'h12}, '{6'h25,6'h12},
    '{6'h27,6'h13}, '{6'h26,6'h13},
    '{6'h36,6'h13},
    '{6'h30,6'h22}, '{6'h31,6'h22}, '{6'h33,6'h23},
    '{6'h34,6'h12}, '{6'h35,6'h12}, '{6'h37,6'h13},
    '{6'h00,6'h00}, '{6'h0e,6'h00}, '{6'h18,6'h00},
    '{6'h22,6'h00}, '{6'h32,6'h00}, '{6'h3f,6'h00}};
  logic clk_sys;
  logic rst;
  logic req_valid;
  logic [31:0] req_word;
  logic instr_valid;
  logic [31:0] instr;
  logic [31:0] w;
  mfd_result_type result;
  mfd_result_type e_mon;
  int error_cnt = 0;
  int compares = 0;

  mfd_fetch_model i_mfd_fetch_model (.clk(clk_sys), .req_valid(req_valid),
    .req_word(req_word), .instr_valid(instr_valid), .instr(instr));
  mfd_decoder i_mfd_decoder (.CLK_SYS(clk_sys), .RST(rst),
    .INSTR_VALID(instr_valid), .INSTR(instr), .RESULT(result));

  function automatic mfd_result_type exp_of(logic r, logic v,
                                            logic [31:0] x);
    mfd_result_type e;
    logic [5:0] a;
    logic alt;
    e = '0;
    a = 6'h00;
    alt = x[24:23] == 2'h1;
    foreach (rows[k])
      if (rows[k].op == x[24:19]) a = rows[k].attr;
    if (r || !v || x[31:30] != 2'h3) return e;
    e.illegal = a == 6'h00 || alt && x[13];
    e.valid = !e.illegal;
    e.opcode = x[24:19];
    e.dest_register = x[29:25];
    e.first_source_register = x[18:14];
    e.op_class = MFD_CLS_NONE;
    if (e.illegal) return e;
    e.op_class = x[24] ? (x[23] ? MFD_CLS_COPRO : MFD_CLS_FP)
                       : (x[23] ? MFD_CLS_ALT : MFD_CLS_INT);
    e.attr = a;
    e.use_immediate = x[13];
    e.second_source_register = x[13] ? 5'h00 : x[4:0];
    e.signed_immediate_field = x[13] ? {{19{x[12]}}, x[12:0]} : 32'h0;
    e.space_id = alt ? x[12:5] : 8'h00;
    return e;
  endfunction

  // Operand fields of a refused word are left open, so they are masked
  task automatic cmp_res(mfd_result_type got, mfd_result_type ex);
    int n;
    n = ex.illegal ? $bits(got) - 29 : 0;
    compares++;
    if ((got >> n) !== (ex >> n)) begin
      error_cnt++;
      $display("MISMATCH %0t result %h expected %h", $time, got, ex);
    end
  endtask

  task automatic send(logic v, logic [31:0] x);
    @(posedge clk_sys);
    req_valid <= v;
    req_word <= x;
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    e_mon = exp_of(rst, instr_valid, instr);
    #1;
    cmp_res(result, e_mon);
  end

  initial begin
    rst = 1'h1;
    req_valid = 1'h1;
    req_word = 32'h0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    foreach (rows[k])
      for (int i = 0; i < 2; i++) begin
        w = {2'h3, k[4:0], rows[k].op, ~k[4:0], i[0],
             k[0] ? 13'h1f81 : 13'h0a7d};
        send(1'h1, w);
      end
    send(1'h1, 32'h8a00_2001);
    send(1'h1, 32'hfe4a_7000);
    send(1'h1, 32'hfe4a_6fff);
    send(1'h1, 32'h3fff_ffff);
    send(1'h0, 32'h0);
    send(1'h1, 32'hc04a_6000);
    rst <= 1'h1;
    send(1'h1, 32'hc04a_6001);
    send(1'h1, 32'hc08a_6002);
    rst <= 1'h0;
    send(1'h1, 32'hc68c_1fe3);
    repeat (3) send(1'h0, 32'h0);
    end_of_test();
  end
endmodule

// File: tb/mfd_fetch_model.sv
// Purpose: Fetch-stage stand-in that feeds words to the decoder
// Assumes: Requests are set by the bench just after a rising edge
// Notes: Released word lines show the inverted last word, not a hold
`timescale 1ns/1ns
module mfd_fetch_model (
  input wire logic clk,
  input wire logic req_valid,
  input wire logic [31:0] req_word,
  output logic instr_valid,
  output logic [31:0] instr
);
  always_ff @(posedge clk) begin
    instr_valid <= req_valid;
  end
  // A stale word must not look decodable by accident
  always_ff @(posedge clk) begin
    instr <= req_valid ? req_word : ~instr;
  end
endmodule
